// File: core/aps_pkg.sv
// Constants, types and helpers shared by the serial audio port
// What this block does
// (R1) I2S master drives bit clock and word select; slave takes them; data output always driven.
// (R2) I2S channel words are sixteen bits, left word MSB on the bus MSB position.
// (R3) I2S word MSB follows each word select change by one bit, on a falling edge.
// (R4) Left samples travel while word select is low, right samples while it is high.
// (R5) I2S data changes on falling bit clock edges, PCM data on rising; the far end samples on the opposite edge.
// (R6) I2S master frames hold 32 or 50 bits at the programmed frame rate.
// (R7) Master bit clock comes from the system clock through an N over M divider.
// (R8) I2S slave follows any external bit clock up to 3.072 MHz.
// (R9) I2S and PCM share the port; exactly one mode is active.
// (R10) PCM master makes bit clock and frame sync; PCM slave takes both as inputs.
// (R11) The PCM setup can be changed at run time by the host.
// (R12) PCM carries up to three full duplex channels in at most sixteen slots.
// (R13) Slot count per frame is 1, 2, 4, 8 or 16, following the interface rate.
// (R14) PCM data output floats during slots this port does not own.
// (R15) At an owned slot's end, output floats after the falling edge of its last bit.
// (R16) Short and long frame sync both work as master and as slave.
// (R17) Short sync is one bit period high once per frame, on a rising edge.
// (R18) Short sync slave sees sync high on a falling edge; slot zero starts next rise.
// (R19) Long sync is three bits high, starting with the first bit of slot zero.
// (R20) Narrowband speech uses 13 of 16 word bits, placement and order configurable.
// (R21) Unused bits are ignored on receive and filled as configured on transmit.
// (R22) After reset the format is 13 bit two's complement, left justified, MSB first.
// (R23) Mode, role, sync, slots and fill are changed only while the port is disabled.
package aps_pkg;

    // Register word indices; byte address is four times the index
    localparam logic [3:0] APS_REG_CTRL = 4'h0;
    localparam logic [3:0] APS_REG_DIV = 4'h1;
    localparam logic [3:0] APS_REG_SLOT = 4'h2;
    localparam logic [3:0] APS_REG_STAT = 4'h3;
    localparam logic [3:0] APS_REG_TX0 = 4'h4;
    localparam logic [3:0] APS_REG_RX0 = 4'h7;
    localparam logic [3:0] APS_REG_LAST = 4'h9;

    // Reset values
    localparam logic [15:0] APS_CTRL_RST = 16'h0100;
    localparam logic [15:0] APS_DIVN_RST = 16'h0001;
    localparam logic [15:0] APS_DIVM_RST = 16'h0002;
    localparam logic [14:0] APS_SLOT_RST = 15'h1000;

    // Framing figures
    localparam int APS_NCH = 3;
    localparam logic [8:0] APS_WORD = 9'h010;
    localparam logic [7:0] APS_I2S32_M1 = 8'h1f;
    localparam logic [7:0] APS_I2S50_M1 = 8'h31;
    localparam logic [7:0] APS_HALF32 = 8'h10;
    localparam logic [7:0] APS_HALF50 = 8'h19;
    localparam logic [7:0] APS_LONG_BITS = 8'h03;
    localparam logic [2:0] APS_MAX_LOG2 = 3'h4;

    // Fill choices for the three spare bits
    typedef enum logic [1:0] {
        APS_FILL_ZERO = 2'h0,
        APS_FILL_ONE = 2'h1,
        APS_FILL_SIGN = 2'h2,
        APS_FILL_PROG = 2'h3
    } aps_fill_t;

    // Port state
    typedef enum logic {
        APS_IDLE = 1'b0,
        APS_RUN = 1'b1
    } aps_state_t;

    // Control register layout, bit 0 first from the bottom
    typedef struct packed {
        logic [2:0] fill_val;
        aps_fill_t fill_mode;
        logic lsb_first;
        logic right_just;
        logic fmt13;
        logic [2:0] slot_log2;
        logic bits50;
        logic long_sync;
        logic master;
        logic pcm;
        logic en;
    } aps_cfg_t;

    // Slot register layout
    typedef struct packed {
        logic [2:0] chen;
        logic [2:0][3:0] sel;
    } aps_slot_t;

    // Bit order reversal
    function automatic logic [15:0] aps_rev(input logic [15:0] w);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 16; i++)
        begin
            r[i] = w[15 - i];
        end
        return r;
    endfunction

    // Byte lane merge for Wishbone writes
    function automatic logic [31:0] aps_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[8 * b +: 8] = wd[8 * b +: 8];
            end
        end
        return r;
    endfunction

endpackage

// File: core/aps_top.sv
// Serial audio port with I2S and multi-slot PCM modes behind a Wishbone slave
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
module aps_top (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Bit clock pin
    input wire logic bclk_pin,
    output logic bclk_drv,
    output logic bclk_oe,
    // Word select or frame sync pin
    input wire logic ws_pin,
    output logic ws_drv,
    output logic ws_oe,
    // Serial data
    input wire logic sd_rx,
    output logic sd_tx,
    output logic sd_tx_oe
);
    import aps_pkg::*;

    // Software state
    aps_cfg_t cfg;
    aps_slot_t slot;
    logic [15:0] div_n;
    logic [15:0] div_m;
    logic [15:0] tx_word [APS_NCH];
    logic [15:0] rx_word [APS_NCH];
    logic [15:0] frames;
    aps_state_t state;

    // Engine state
    logic [15:0] acc;
    logic bclk_prev;
    logic [7:0] bitpos;
    logic ws_smp;
    logic ws_last;
    logic fs_prev;
    logic sync_hit;
    logic [4:0] wbit;
    logic cur_val;
    logic [3:0] cur_pos;
    logic [1:0] cur_ch;
    logic [15:0] rsh;

    // Bus decode
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_take = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    wire [3:0] bus_idx = wb_adr_i[5:2];
    wire bus_hit = (wb_adr_i[7:6] == 2'h0) & (wb_adr_i[1:0] == 2'h0)
                 & (bus_idx <= APS_REG_LAST);
    wire [1:0] tx_sel = 2'(bus_idx - APS_REG_TX0);
    wire [1:0] rx_sel = 2'(bus_idx - APS_REG_RX0);
    wire is_tx = (bus_idx >= APS_REG_TX0) & (bus_idx < APS_REG_RX0);
    wire is_rx = (bus_idx >= APS_REG_RX0);
    wire run = (state == APS_RUN);

    // Read selection; unmapped words read zero
    wire [31:0] rd_val =
        !bus_hit ? 32'h0 :
        (bus_idx == APS_REG_CTRL) ? {16'h0, cfg} :
        (bus_idx == APS_REG_DIV) ? {div_m, div_n} :
        (bus_idx == APS_REG_SLOT) ? {17'h0, slot} :
        (bus_idx == APS_REG_STAT) ? {15'h0, run, frames} :
        is_tx ? {16'h0, tx_word[tx_sel]} :
        is_rx ? {16'h0, rx_word[rx_sel]} : 32'h0;
    wire [31:0] wr_val = aps_merge(rd_val, wb_dat_i, wb_sel_i);

    // Settings lock while enabled; only the enable bit may move
    wire [15:0] next_cfg = cfg.en ? {cfg[15:1], wr_val[0]} : wr_val[15:0]; // R23
    wire wr_ok = bus_take & bus_hit;
    wire cfg_free = ~cfg.en; // R23

    // Bus answer one cycle after the request
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_val : 32'h0;
        end
    end

    // Register writes; host may reconfigure at run time between sessions
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cfg <= APS_CTRL_RST; // R22
            div_n <= APS_DIVN_RST;
            div_m <= APS_DIVM_RST;
            slot <= APS_SLOT_RST;
        end
        else if (wr_ok)
        begin
            if (bus_idx == APS_REG_CTRL)
                cfg <= next_cfg; // R11 R9
            if (bus_idx == APS_REG_DIV && cfg_free)
                {div_m, div_n} <= wr_val; // R7
            if (bus_idx == APS_REG_SLOT && cfg_free)
                slot <= wr_val[14:0]; // R12
        end
    end

    // Transmit words
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            for (int c = 0; c < APS_NCH; c++)
                tx_word[c] <= 16'h0;
        end
        else if (wr_ok & is_tx)
        begin
            tx_word[tx_sel] <= wr_val[15:0];
        end
    end

    // Port state follows the enable one cycle later
    always_ff @(posedge clock)
    begin
        if (rst)
            state <= APS_IDLE;
        else
            state <= cfg.en ? APS_RUN : APS_IDLE;
    end

    // Fractional N over M divider; each overflow is one half bit
    wire [16:0] acc_sum = {1'b0, acc} + {1'b0, div_n};
    wire [16:0] acc_wrap = acc_sum - {1'b0, div_m};
    wire tick = run & cfg.master & (acc_sum >= {1'b0, div_m}); // R7
    wire [15:0] next_acc = !(run & cfg.master) ? 16'h0 :
                           tick ? acc_wrap[15:0] : acc_sum[15:0];

    // Bit clock edges, generated or followed
    wire rise = run & (cfg.master ? (tick & ~bclk_drv) : (bclk_pin & ~bclk_prev)); // R8
    wire fall = run & (cfg.master ? (tick & bclk_drv) : (~bclk_pin & bclk_prev)); // R8
    wire launch = cfg.pcm ? rise : fall; // R5
    wire capture = cfg.pcm ? fall : rise;

    // Bit clock generation and pin direction
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            acc <= 16'h0;
            bclk_drv <= 1'b0;
            bclk_prev <= 1'b0;
            bclk_oe <= 1'b0;
            ws_oe <= 1'b0;
        end
        else
        begin
            acc <= next_acc;
            bclk_drv <= tick ? ~bclk_drv : (bclk_drv & run & cfg.master);
            bclk_prev <= bclk_pin;
            bclk_oe <= run & cfg.master; // R1 R10
            ws_oe <= run & cfg.master; // R1 R10
        end
    end

    // Frame length
    wire [2:0] lg = (cfg.slot_log2 > APS_MAX_LOG2) ? APS_MAX_LOG2 : cfg.slot_log2; // R13
    wire [8:0] pcm_len = APS_WORD << lg; // R12
    wire [8:0] pcm_m1 = pcm_len - 9'h001;
    wire [7:0] i2s_m1 = cfg.bits50 ? APS_I2S50_M1 : APS_I2S32_M1; // R6
    wire [7:0] flen_m1 = cfg.pcm ? pcm_m1[7:0] : i2s_m1;
    wire [7:0] half = cfg.bits50 ? APS_HALF50 : APS_HALF32;
    wire [7:0] bp_inc = (bitpos == flen_m1) ? 8'h00 : bitpos + 8'h01;

    // Slave resync: short sync puts bit zero next, long sync is already in bit zero
    wire resync = cfg.pcm & ~cfg.master & sync_hit; // R16
    wire [7:0] next_bp = !resync ? bp_inc : (cfg.long_sync ? 8'h01 : 8'h00); // R18 R19
    wire sync_seen = cfg.long_sync ? (ws_pin & ~fs_prev) : ws_pin; // R18

    // Master word select or frame sync level for the next bit
    wire long_lvl = (next_bp < APS_LONG_BITS); // R19
    wire short_lvl = (next_bp == flen_m1); // R17
    wire pcm_lvl = cfg.long_sync ? long_lvl : short_lvl;
    wire ws_next = cfg.pcm ? pcm_lvl : (next_bp >= half); // R4

    // Framing counters and sync tracking
    always_ff @(posedge clock)
    begin
        if (rst || !run)
        begin
            bitpos <= flen_m1;
            ws_drv <= 1'b0;
            ws_smp <= 1'b0;
            fs_prev <= 1'b0;
            sync_hit <= 1'b0;
        end
        else
        begin
            if (launch)
            begin
                bitpos <= next_bp;
                ws_drv <= cfg.master & ws_next; // R17 R19
                sync_hit <= 1'b0;
            end
            if (rise)
                ws_smp <= ws_pin;
            if (fall)
            begin
                fs_prev <= ws_pin;
                sync_hit <= sync_seen; // R18
            end
        end
    end

    // Spare bit fill and sample placement per channel
    wire nb = cfg.pcm & cfg.fmt13; // R20
    logic [15:0] fmt_word [APS_NCH];
    for (genvar c = 0; c < APS_NCH; c++)
    begin : g_fmt
        wire [12:0] smp = tx_word[c][12:0];
        wire [2:0] fill =
            (cfg.fill_mode == APS_FILL_ZERO) ? 3'h0 :
            (cfg.fill_mode == APS_FILL_ONE) ? 3'h7 :
            (cfg.fill_mode == APS_FILL_SIGN) ? {3{smp[12]}} : cfg.fill_val; // R21
        wire [15:0] placed = cfg.right_just ? {fill, smp} : {smp, fill}; // R20
        wire [15:0] ordered = cfg.lsb_first ? aps_rev(placed) : placed; // R20
        assign fmt_word[c] = nb ? ordered : tx_word[c];
    end

    // I2S word tracking
    wire ws_cur = cfg.master ? ws_drv : ws_smp;
    wire ws_flip = (ws_cur != ws_last); // R3
    wire i2s_more = (wbit < 5'h10); // R2

    // PCM slot ownership for the next bit
    wire [3:0] nslot = next_bp[7:4];
    wire [2:0] ch_hit;
    for (genvar c = 0; c < APS_NCH; c++)
    begin : g_own
        assign ch_hit[c] = slot.chen[c] & (slot.sel[c] == nslot); // R12
    end
    wire [1:0] hit_ch = ch_hit[0] ? 2'h0 : (ch_hit[1] ? 2'h1 : 2'h2);

    // Next launched bit
    wire l_val = cfg.pcm ? (|ch_hit) : (ws_flip | i2s_more); // R14 R2
    wire [3:0] l_pos = cfg.pcm ? next_bp[3:0] : (ws_flip ? 4'h0 : wbit[3:0]); // R3
    wire [1:0] l_ch = cfg.pcm ? hit_ch : {1'b0, ws_cur}; // R4
    wire [15:0] l_word = fmt_word[l_ch];
    wire l_bit = l_val & l_word[4'hf - l_pos];

    // Receive assembly; spare bits dropped, sample sign extended
    wire [15:0] rsh_next = {rsh[14:0], sd_rx};
    wire rx_done = capture & cur_val & (cur_pos == 4'hf);
    wire [15:0] rx_ord = (nb & cfg.lsb_first) ? aps_rev(rsh_next) : rsh_next;
    wire [12:0] rx13 = cfg.right_just ? rx_ord[12:0] : rx_ord[15:3]; // R21
    wire [15:0] rx_val = nb ? {{3{rx13[12]}}, rx13} : rx_ord;
    wire frame_mark = cfg.pcm | cfg.master ? ((next_bp == 8'h00) | resync)
                                           : (ws_flip & ~ws_cur);

    // I2S word bit counter
    always_ff @(posedge clock)
    begin
        if (rst || !run)
        begin
            wbit <= 5'h10;
            ws_last <= 1'b0;
        end
        else if (launch & ~cfg.pcm)
        begin
            ws_last <= ws_cur;
            wbit <= ws_flip ? 5'h01 : (i2s_more ? wbit + 5'h01 : wbit); // R3 R2
        end
    end

    // Serial data launch, output enable and capture
    always_ff @(posedge clock)
    begin
        if (rst || !run)
        begin
            cur_val <= 1'b0;
            cur_pos <= 4'h0;
            cur_ch <= 2'h0;
            sd_tx <= 1'b0;
            sd_tx_oe <= ~cfg.pcm; // R1
            rsh <= 16'h0;
        end
        else
        begin
            if (launch)
            begin
                cur_val <= l_val;
                cur_pos <= l_pos;
                cur_ch <= l_ch;
                sd_tx <= l_bit; // R5
                sd_tx_oe <= ~cfg.pcm | l_val; // R14 R1
            end
            else if (rx_done)
            begin
                cur_val <= 1'b0;
                sd_tx_oe <= ~cfg.pcm; // R15
            end
            if (capture & cur_val)
                rsh <= rsh_next;
        end
    end

    // Received words and frame count
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            for (int c = 0; c < APS_NCH; c++)
                rx_word[c] <= 16'h0;
            frames <= 16'h0;
        end
        else
        begin
            if (rx_done)
                rx_word[cur_ch] <= rx_val; // R21
            if (run & launch & frame_mark)
                frames <= frames + 16'h0001;
        end
    end

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    sequence s_ws_flip;
        launch && !cfg.pcm && ws_flip;
    endsequence

    sequence s_slot_end;
        capture && cfg.pcm && cur_val && cur_pos == 4'hf;
    endsequence

    chk_bus_ack: assert property (s_bus_req |=> s_ack_pulse)
        else $error("Bus request not answered in one cycle");

    chk_clock_dir: assert property (run && cfg.master ##1 run |-> bclk_oe && ws_oe) // R1
        else $error("Master does not drive bit clock and word select");

    chk_i2s_drive: assert property (run && !cfg.pcm |=> sd_tx_oe) // R1
        else $error("I2S data output not driven");

    chk_msb_lag: assert property (s_ws_flip |=> cur_val && cur_pos == 4'h0) // R3
        else $error("Word MSB not launched one bit after word select change");

    chk_word_len: assert property (launch && !cfg.pcm && !ws_flip && wbit == 5'h10
                                   |=> !cur_val) // R2
        else $error("I2S word longer than sixteen bits");

    chk_left_low: assert property (run && !cfg.pcm && cur_val |-> cur_ch[0] == ws_last) // R4
        else $error("I2S channel does not match word select level");

    chk_slot_release: assert property (s_slot_end |=> !sd_tx_oe) // R15
        else $error("Output still driven after last bit of slot");

    chk_slot_own: assert property (run && cfg.pcm && sd_tx_oe |-> cur_val) // R14
        else $error("Output driven in an unowned slot");

    chk_short_sync: assert property (run && cfg.pcm && cfg.master && !cfg.long_sync
                                     && ws_drv |-> bitpos == flen_m1) // R17
        else $error("Short sync not in the bit before slot zero");

    chk_long_sync: assert property (run && cfg.pcm && cfg.master && cfg.long_sync
                                    && ws_drv |-> bitpos < APS_LONG_BITS) // R19
        else $error("Long sync outside the first three bits");

    chk_cfg_lock: assert property (cfg.en && $past(cfg.en) |-> $stable(cfg[15:1])) // R23
        else $error("Configuration changed while enabled");

endmodule

// File: tb/aps_codec.sv
// Behavioural far-end audio codec for the serial audio port bench
module aps_codec #(
    parameter logic [15:0] TXL = 16'h9a5e,
    parameter logic [15:0] TXR = 16'h4c21,
    parameter int HALF = 41
) (
    // Clock and generator enable
    input wire logic clock,
    input wire logic gen,
    // Line levels seen on the bus
    input wire logic bclk,
    input wire logic ws,
    input wire logic sd_in,
    // Levels driven by the codec
    output logic bclk_out,
    output logic ws_out,
    output logic sd_out,
    // Captured words and measured frame length
    output logic [15:0] left,
    output logic [15:0] right,
    output logic [7:0] fbits
);
    timeunit 1ns;
    timeprecision 100ps;
    logic pb = 1'b0;
    logic pws_r = 1'b0;
    logic pws_f = 1'b0;
    logic [15:0] sh = 16'h0;
    logic [15:0] w;
    logic lsb;
    int div = 0;
    int bit_no = 0;
    int rcnt = 0;
    int kcnt = 0;
    int fcnt = 0;
    int k;
    initial
    begin
        bclk_out = 1'b0;
        ws_out = 1'b0;
        sd_out = 1'b0;
        left = 16'h0;
        right = 16'h0;
        fbits = 8'h00;
    end
    // Bit clock of about 3.05 MHz, halted between runs; ws moves on falling edges
    always @(posedge clock)
    begin
        pb <= bclk;
        if (!gen)
        begin
            div <= 0;
            bclk_out <= 1'b0;
        end
        else if (div == HALF - 1)
        begin
            div <= 0;
            bclk_out <= ~bclk_out;
            if (bclk_out)
            begin
                bit_no <= (bit_no + 1) % 32;
                ws_out <= ((bit_no + 1) % 32) >= 16;
            end
        end
        else
        begin
            div <= div + 1;
        end
        // Rising edge: sample data, count bits per frame
        if (bclk && !pb)
        begin
            k = (ws !== pws_r) ? 0 : rcnt + 1;
            rcnt <= k;
            pws_r <= ws;
            sh <= {sh[14:0], sd_in};
            // Word ends at its 16th bit, or at the next ws change in a 32 bit frame
            if ((k == 16 && !ws) || (k == 0 && ws && rcnt == 15))
            begin
                left <= {sh[14:0], sd_in};
            end
            if ((k == 16 && ws) || (k == 0 && !ws && rcnt == 15))
            begin
                right <= {sh[14:0], sd_in};
            end
            if (ws && !pws_r)
            begin
                fbits <= 8'(fcnt);
                fcnt <= 1;
            end
            else
            begin
                fcnt <= fcnt + 1;
            end
        end
        // Falling edge: launch MSB one bit after ws change, else a changing level
        if (!bclk && pb)
        begin
            k = (ws !== pws_f) ? 0 : kcnt + 1;
            kcnt <= k;
            pws_f <= ws;
            // Slave runs send inverted words so their capture differs from master runs
            w = (ws ? TXR : TXL) ^ {16{gen}};
            // In a 32 bit frame the LSB goes out in the bit where ws has already moved
            lsb = (pws_f ? TXR[0] : TXL[0]) ^ gen;
            sd_out <= (k >= 1 && k <= 16) ? w[16 - k] :
                      (k == 0 && kcnt == 15) ? lsb : ~sd_out;
        end
    end
endmodule

// File: tb/aps_tb_top.sv
// Self-checking bench for the serial audio port
module aps_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import aps_pkg::*;
    // One row of the register walk
    typedef struct packed {
        logic we;
        logic [7:0] adr;
        logic [31:0] wd;
        logic [31:0] exp;
    } aps_row_t;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0;
    logic gen = 1'b0;
    logic [31:0] rdat, q;
    logic ack, bclk_drv, bclk_oe, ws_drv, ws_oe, sd_tx, sd_tx_oe, cod_bclk, cod_ws, cod_sd;
    logic [15:0] left, right;
    logic [7:0] fbits;
    int errors = 0;
    int comparisons = 0;
    int hi, lo;
    aps_row_t rows [8];
    wire logic bclk_line = bclk_oe ? bclk_drv : cod_bclk;
    wire logic ws_line = ws_oe ? ws_drv : cod_ws;

    // Design and far end
    aps_top i_aps_top (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .bclk_pin(bclk_line), .bclk_drv(bclk_drv), .bclk_oe(bclk_oe), .ws_pin(ws_line),
        .ws_drv(ws_drv), .ws_oe(ws_oe), .sd_rx(cod_sd), .sd_tx(sd_tx), .sd_tx_oe(sd_tx_oe));
    aps_codec i_aps_codec (.clock(clock), .gen(gen), .bclk(bclk_line), .ws(ws_line),
        .sd_in(sd_tx), .bclk_out(cod_bclk), .ws_out(cod_ws), .sd_out(cod_sd), .left(left),
        .right(right), .fbits(fbits));

    // 250 MHz clock
    initial
    begin
        forever #2 clock = ~clock;
    end

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Classic Wishbone cycle; read data lands in q
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        q = rdat;
        chk({31'h0, ack}, 32'h1, "bus answer");
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        wb(1'b0, a, 32'h0);
        chk(q, exp, what);
    endtask

    // Width of one master frame sync pulse in system clocks
    task automatic sync_width(input int exp, input string what);
        int n;
        n = 0;
        while (ws_drv !== 1'b1)
        begin
            @(posedge clock);
        end
        while (ws_drv === 1'b1)
        begin
            @(posedge clock);
            n++;
        end
        chk(n, exp, what);
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Watchdog
    initial
    begin
        repeat (30000) @(posedge clock);
        errors++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        rows[0] = '{1'b0, 8'h00, 32'h0, 32'h00000100};
        rows[1] = '{1'b0, 8'h04, 32'h0, 32'h00020001};
        rows[2] = '{1'b0, 8'h08, 32'h0, 32'h00001000};
        rows[3] = '{1'b0, 8'h0c, 32'h0, 32'h0};
        rows[4] = '{1'b1, 8'h10, 32'hffffa5c3, 32'h0000a5c3};
        rows[5] = '{1'b1, 8'h1c, 32'h1234, 32'h0};
        rows[6] = '{1'b1, 8'h28, 32'hdead, 32'h0};
        rows[7] = '{1'b1, 8'h3c, 32'h5, 32'h0};
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            if (rows[i].we)
            begin
                wb(1'b1, rows[i].adr, rows[i].wd);
            end
            rd(rows[i].adr, rows[i].exp, "register");
        end
        // I2S master, 32 bit frames
        wb(1'b1, 8'h14, 32'h3c5a);
        wb(1'b1, 8'h00, 32'h0105);
        repeat (800) @(posedge clock);
        chk({16'h0, left}, 32'ha5c3, "left word");
        chk({16'h0, right}, 32'h3c5a, "right word");
        chk({24'h0, fbits}, 32'd32, "frame bits");
        chk({29'h0, bclk_oe, ws_oe, sd_tx_oe}, 32'h7, "master drives");
        rd(8'h1c, 32'h9a5e, "rx left");
        rd(8'h20, 32'h4c21, "rx right");
        wb(1'b1, 8'h04, 32'h00050001);
        rd(8'h04, 32'h00020001, "divider locked");
        // I2S master, 50 bit frames
        wb(1'b1, 8'h00, 32'h0104);
        wb(1'b1, 8'h00, 32'h0115);
        repeat (1200) @(posedge clock);
        chk({24'h0, fbits}, 32'd50, "frame bits");
        // I2S slave from the codec clock
        wb(1'b1, 8'h00, 32'h0114);
        wb(1'b1, 8'h10, 32'h0ff0);
        gen <= 1'b1;
        wb(1'b1, 8'h00, 32'h0101);
        repeat (6000) @(posedge clock);
        chk({16'h0, left}, 32'h0ff0, "slave left");
        chk({30'h0, bclk_oe, ws_oe}, 32'h0, "slave inputs");
        rd(8'h1c, 32'h65a1, "slave rx left");
        rd(8'h20, 32'hb3de, "slave rx right");
        // PCM master, two slots, channel 0 in slot 1
        wb(1'b1, 8'h00, 32'h0100);
        gen <= 1'b0;
        wb(1'b1, 8'h08, 32'h1001);
        wb(1'b1, 8'h00, 32'h0127);
        // With N=1 and M=2 one bit lasts four system clocks
        sync_width(4, "short sync");
        hi = 0;
        lo = 0;
        repeat (400)
        begin
            @(posedge clock);
            hi += (sd_tx_oe === 1'b1);
            lo += (sd_tx_oe === 1'b0);
        end
        chk({31'h0, hi > 0 && lo > 0}, 32'h1, "slot float");
        chk({31'h0, ws_oe}, 32'h1, "sync driven");
        wb(1'b0, 8'h0c, 32'h0);
        chk({31'h0, q[16]}, 32'h1, "running");
        // PCM master, long frame sync of three bits
        wb(1'b1, 8'h00, 32'h0126);
        wb(1'b1, 8'h00, 32'h012f);
        sync_width(12, "long sync");
        // Reset in mid-run returns the port to idle I2S with reset settings
        rst <= 1'b1;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        chk({29'h0, bclk_oe, ws_oe, sd_tx_oe}, 32'h1, "reset pins");
        rd(8'h00, 32'h00000100, "reset ctrl");
        rd(8'h0c, 32'h0, "reset stat");
        rd(8'h10, 32'h0, "reset tx");
        end_sim();
    end
endmodule
